// ===== design/sdspi_pkg.sv
// Shared constants of the stepper drive configuration link.
// Assumes a 50 MHz core clock at both ends of the link.
package sdspi_pkg;

  localparam int          CLK_HZ        = 50_000_000;
  localparam int          SCLK_HZ       = 25_000;
  localparam int          SCK_HALF_INT  = CLK_HZ / (2 * SCLK_HZ);
  localparam logic [10:0] SCK_HALF_CYC  = 11'(SCK_HALF_INT);

  localparam int          CS_SETUP_NS   = 20_000;
  localparam int          CS_HOLD_NS    = 1_000;
  localparam int          CS_IDLE_NS    = 20_000;
  localparam int          CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam logic [10:0] CS_SETUP_CYC  = 11'((CS_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] CS_HOLD_CYC   = 11'((CS_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] CS_IDLE_CYC   = 11'((CS_IDLE_NS + CLK_NS - 1) / CLK_NS);

  localparam int          BYTE_W        = 8;
  localparam logic [7:0]  CMD_READ_ALL  = 8'h40;
  localparam logic [7:0]  CMD_WRITE_ALL = 8'h80;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  // Arbitrary value for the header byte that opens every bulk read.
  localparam logic [7:0]  READ_HEADER   = 8'h5a;
  localparam logic [7:0]  READ_FILLERS  = 8'h0f;

  localparam int          NUM_PARAM     = 13;
  localparam logic [3:0]  PARAM_CNT     = 4'hd;
  localparam logic [7:0]  PARAM_RST [NUM_PARAM] = '{
    8'h10, 8'h01, 8'h41, 8'h42, 8'h43, 8'h05, 8'h19,
    8'h00, 8'h01, 8'h01, 8'hf4, 8'h00, 8'h00
  };

endpackage

// ===== design/sdspi_if.sv
// Four-wire serial link between the configuration master and one drive.
// Assumes the drive's output is pulled high when nobody drives it.
`timescale 1ns/1ns
interface sdspi_if;
  logic sclk;
  logic mosi;
  logic cs_n;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // An undriven data-out line floats high through its pull-up.
  assign miso = miso_oe ? miso_o : 1'b1;

  modport master (output sclk, output mosi, output cs_n, input miso);
  modport slave  (input sclk, input mosi, input cs_n, output miso_o, output miso_oe);
endinterface

// ===== design/sdspi_drive.sv
// Drive end of the configuration link: bulk read and bulk write of setup bytes.
// Assumes the link pins are asynchronous to i_core_clk and the clock idles low.
//
// Function
// - Eight-bit bytes, most significant bit and byte first.
// - Master clocks the link at 25 kHz.
// - Drive captures incoming bits on rising edge.
// - Drive changes outgoing bit on falling edge.
// - One bit out per bit in, full duplex.
// - Only the master starts frames.
// - Deselected drive ignores link, releases its output.
// - Shared writes load identical values into every drive.
// - Master writes only while drive is disabled.
// - Read-all 0x40 plus 15 fillers returns parameters.
// - Read response opens with a fixed header.
// - Write-all 0x80, parameters, then checksum byte.
// - Drive answers 0xFF during a bulk write.
`timescale 1ns/1ns
module sdspi_drive
  import sdspi_pkg::*;
(
  input  wire logic       i_core_clk,             // Core clock, 50 MHz.
  input  wire logic       i_rst,                  // Synchronous reset, active high.
  sdspi_if.slave          bus,                    // Link pins.
  input  wire logic [7:0] i_fault,                // Fault code of the drive.
  input  wire logic       i_drive_enabled,        // Drive running; writes are refused.
  output logic [7:0]      o_param [NUM_PARAM],    // Current setup bytes.
  output logic            o_cfg_done,             // Pulse: new setup loaded.
  output logic            o_cfg_err,              // Pulse: write checksum mismatch.
  output logic            o_cfg_refused,          // Pulse: write refused, drive enabled.
  output logic            o_busy                  // Drive is selected.
);

  typedef enum logic [1:0] {D_CMD, D_READ, D_WRITE, D_DONE} sdspi_dstate_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [2:0]    meta_r;
  logic [2:0]    sync_r;
  logic          sck_d_r;
  logic          sck_s;
  logic          mosi_s;
  logic          cs_act;
  logic          rise;
  logic          fall;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      meta_r  <= 3'h1;
      sync_r  <= 3'h1;
      sck_d_r <= 1'b0;
    end
    else
    begin
      meta_r  <= {bus.sclk, bus.mosi, bus.cs_n};
      sync_r  <= meta_r;
      sck_d_r <= sync_r[2];
    end
  end

  assign sck_s  = sync_r[2];
  assign mosi_s = sync_r[1];
  assign cs_act = ~sync_r[0];
  assign rise   = cs_act & sck_s & ~sck_d_r;
  assign fall   = cs_act & ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bit shifting in both directions.

  logic [2:0]    bit_r;
  logic [7:0]    rx_r;
  logic [7:0]    tx_r;
  logic [7:0]    tx_next_r;
  logic [7:0]    byte_in;
  logic          byte_done;

  assign byte_in   = {rx_r[6:0], mosi_s};
  assign byte_done = rise & (bit_r == 3'h7);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !cs_act)
    begin
      bit_r <= 3'h0;
      rx_r  <= 8'h00;
    end
    else if (rise)
    begin
      rx_r  <= byte_in;
      bit_r <= bit_r + 3'h1;
    end
  end

  // The first bit of a frame is already on the line when the master selects us.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !cs_act)
    begin
      tx_r <= FILL_BYTE;
    end
    else if (fall)
    begin
      if (bit_r == 3'h0)
      begin
        tx_r <= tx_next_r;
      end
      else
      begin
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end

  assign bus.miso_o  = tx_r[7];
  assign bus.miso_oe = cs_act;
  assign o_busy      = cs_act;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing.

  sdspi_dstate_t state_r;
  logic [3:0]    idx_r;
  logic [7:0]    sum_r;
  logic [7:0]    stage_r [NUM_PARAM];
  logic [7:0]    param_r [NUM_PARAM];
  logic          ck_byte;
  logic          ck_good;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !cs_act)
    begin
      state_r   <= D_CMD;
      idx_r     <= 4'h0;
      sum_r     <= 8'h00;
      tx_next_r <= FILL_BYTE;
    end
    else if (byte_done)
    begin
      unique case (state_r)
        D_CMD:
        begin
          idx_r <= 4'h0;
          sum_r <= 8'h00;
          if (byte_in == CMD_READ_ALL)
          begin
            state_r   <= D_READ;
            tx_next_r <= READ_HEADER;
          end
          else if (byte_in == CMD_WRITE_ALL)
          begin
            state_r   <= D_WRITE;
            tx_next_r <= FILL_BYTE;
          end
          else
          begin
            state_r   <= D_DONE;
            tx_next_r <= FILL_BYTE;
          end
        end
        D_READ:
        begin
          if (idx_r < PARAM_CNT)
          begin
            tx_next_r <= param_r[idx_r];
            idx_r     <= idx_r + 4'h1;
          end
          else if (idx_r == PARAM_CNT)
          begin
            tx_next_r <= i_fault;
            idx_r     <= idx_r + 4'h1;
          end
          else
          begin
            tx_next_r <= FILL_BYTE;
            state_r   <= D_DONE;
          end
        end
        D_WRITE:
        begin
          tx_next_r <= FILL_BYTE;
          if (idx_r < PARAM_CNT)
          begin
            sum_r <= sum_r + byte_in;
            idx_r <= idx_r + 4'h1;
          end
          else
          begin
            state_r <= D_DONE;
          end
        end
        D_DONE:
        begin
          tx_next_r <= FILL_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (byte_done && state_r == D_WRITE && idx_r < PARAM_CNT)
    begin
      stage_r[idx_r] <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store; a write takes effect only after a good checksum.

  assign ck_byte = byte_done & (state_r == D_WRITE) & (idx_r == PARAM_CNT);
  assign ck_good = (byte_in == sum_r);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < NUM_PARAM; i++)
      begin
        param_r[i] <= PARAM_RST[i];
      end
    end
    else if (ck_byte && ck_good && !i_drive_enabled)
    begin
      for (int i = 0; i < NUM_PARAM; i++)
      begin
        param_r[i] <= stage_r[i];
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_cfg_done    <= 1'b0;
      o_cfg_err     <= 1'b0;
      o_cfg_refused <= 1'b0;
    end
    else
    begin
      o_cfg_done    <= ck_byte & ck_good & ~i_drive_enabled;
      o_cfg_err     <= ck_byte & ~ck_good;
      o_cfg_refused <= ck_byte & ck_good & i_drive_enabled;
    end
  end

  assign o_param = param_r;

endmodule

// ===== design/sdspi_master.sv
// Master end of the configuration link, with a transmit byte FIFO.
// Assumes the drive data-out is asynchronous to i_core_clk.
`timescale 1ns/1ns
module sdspi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_core_clk,   // Core clock.
  input  wire logic             i_rst,        // Synchronous reset, active high.
  input  wire logic             i_wr_valid,   // Write request.
  output logic                  o_wr_ready,   // Room for a word.
  input  wire logic [WIDTH-1:0] i_wr_data,    // Word written.
  output logic                  o_rd_valid,   // A word is held.
  input  wire logic             i_rd_ready,   // Reader takes the word.
  output logic [WIDTH-1:0]      o_rd_data     // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign o_wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt_r != '0);
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = o_rd_valid & i_rd_ready;
  assign o_rd_data  = mem_r[rp_r];

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop)
      begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= i_wr_data;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

module sdspi_master
  import sdspi_pkg::*;
#(
  // The default gives the 25 kHz link clock; a bench may shorten it to keep runs brief.
  parameter logic [10:0] HALF_CYC = SCK_HALF_CYC  // Core cycles per link clock half period.
) (
  input  wire logic       i_core_clk,   // Core clock, 50 MHz.
  input  wire logic       i_rst,        // Synchronous reset, active high.
  sdspi_if.master         bus,          // Link pins.
  input  wire logic       i_tx_valid,   // Byte to send is offered.
  input  wire logic [7:0] i_tx_data,    // Byte to send.
  output logic            o_tx_ready,   // FIFO takes the byte.
  input  wire logic       i_hold,       // Keep the frame open while the FIFO is empty.
  output logic            o_rx_valid,   // Pulse: a received byte.
  output logic [7:0]      o_rx_data,    // Received byte.
  output logic            o_busy        // Frame in progress.
);

  typedef enum logic [2:0] {M_IDLE, M_LEAD, M_LOW, M_HIGH, M_WAIT, M_TRAIL, M_GAP}
    sdspi_mstate_t;

  logic          f_valid;
  logic          f_pop;
  logic [7:0]    f_data;

  sdspi_fifo #(.WIDTH(BYTE_W), .DEPTH(8)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .i_wr_data  (i_tx_data),
    .o_rd_valid (f_valid),
    .i_rd_ready (f_pop),
    .o_rd_data  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data-in synchroniser.

  logic          miso_meta_r;
  logic          miso_s_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      miso_meta_r <= 1'b1;
      miso_s_r    <= 1'b1;
    end
    else
    begin
      miso_meta_r <= bus.miso;
      miso_s_r    <= miso_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; the link clock is divided down from the core clock.

  sdspi_mstate_t state_r;
  logic [10:0]   cnt_r;
  logic [2:0]    bit_r;
  logic [7:0]    tx_r;
  logic [7:0]    rx_r;
  logic          sclk_r;
  logic          cs_n_r;
  logic          load;

  // A byte is pulled when the frame opens, at a byte boundary, or after a stall.
  assign load  = f_valid & ((state_r == M_IDLE) | (state_r == M_WAIT) |
                 ((state_r == M_HIGH) & (cnt_r == HALF_CYC - 11'h1) & (bit_r == 3'h7)));
  assign f_pop = load;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r <= M_IDLE;
      cnt_r   <= 11'h0;
      bit_r   <= 3'h0;
      tx_r    <= FILL_BYTE;
      rx_r    <= 8'h00;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 11'h1;
      unique case (state_r)
        M_IDLE:
        begin
          cnt_r <= 11'h0;
          if (f_valid)
          begin
            cs_n_r  <= 1'b0;
            tx_r    <= f_data;
            bit_r   <= 3'h0;
            state_r <= M_LEAD;
          end
        end
        M_LEAD:
        begin
          if (cnt_r == CS_SETUP_CYC - 11'h1)
          begin
            cnt_r   <= 11'h0;
            state_r <= M_LOW;
          end
        end
        M_LOW:
        begin
          if (cnt_r == HALF_CYC - 11'h1)
          begin
            cnt_r   <= 11'h0;
            sclk_r  <= 1'b1;
            rx_r    <= {rx_r[6:0], miso_s_r};
            state_r <= M_HIGH;
          end
        end
        M_HIGH:
        begin
          if (cnt_r == HALF_CYC - 11'h1)
          begin
            cnt_r  <= 11'h0;
            sclk_r <= 1'b0;
            bit_r  <= bit_r + 3'h1;
            if (bit_r != 3'h7)
            begin
              tx_r    <= {tx_r[6:0], 1'b1};
              state_r <= M_LOW;
            end
            else if (f_valid)
            begin
              tx_r    <= f_data;
              state_r <= M_LOW;
            end
            else
            begin
              state_r <= i_hold ? M_WAIT : M_TRAIL;
            end
          end
        end
        M_WAIT:
        begin
          cnt_r <= 11'h0;
          if (f_valid)
          begin
            tx_r    <= f_data;
            state_r <= M_LOW;
          end
          else if (!i_hold)
          begin
            state_r <= M_TRAIL;
          end
        end
        M_TRAIL:
        begin
          if (cnt_r == CS_HOLD_CYC - 11'h1)
          begin
            cnt_r   <= 11'h0;
            cs_n_r  <= 1'b1;
            state_r <= M_GAP;
          end
        end
        M_GAP:
        begin
          if (cnt_r == CS_IDLE_CYC - 11'h1)
          begin
            cnt_r   <= 11'h0;
            state_r <= M_IDLE;
          end
        end
        default:
        begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      if (state_r == M_HIGH && cnt_r == 11'h0 && bit_r == 3'h7)
      begin
        o_rx_valid <= 1'b1;
        o_rx_data  <= rx_r;
      end
    end
  end

  assign bus.sclk = sclk_r;
  assign bus.mosi = tx_r[7];
  assign bus.cs_n = cs_n_r;
  assign o_busy   = ~cs_n_r | (state_r != M_IDLE);

endmodule

// ===== tb/sdspi_checker.sv
// Link checker: watches the pins between the master end and the drive end.
// Assumes one 50 MHz core clock and a synchronous active-high reset.
`timescale 1ns/1ns
module sdspi_checker
  import sdspi_pkg::*;
#(
  parameter logic [10:0] HALF_CYC = SCK_HALF_CYC  // Expected link clock high phase, in cycles.
) (
  input  wire logic i_core_clk, // Core clock.
  input  wire logic i_rst,      // Reset.
  input  wire logic sclk,       // Link clock.
  input  wire logic mosi,       // Master data.
  input  wire logic cs_n,       // Select.
  input  wire logic miso_o,     // Drive data bit.
  input  wire logic miso_oe,    // Drive enable.
  input  wire logic miso        // Resolved drive data.
);
  logic [10:0] hi_cnt_r;
  logic [7:0]  rise_cnt_r;
  logic        sclk_q_r;

  ////////////////////////////////////////
  // High-phase length and rising edges seen in the current frame.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !sclk)
      hi_cnt_r <= 11'h000;
    else
      hi_cnt_r <= hi_cnt_r + 11'h001;
  end

  always_ff @(posedge i_core_clk)
  begin
    sclk_q_r <= i_rst ? 1'b0 : sclk;
    if (i_rst || cs_n)
      rise_cnt_r <= 8'h00;
    else if (sclk && !sclk_q_r)
      rise_cnt_r <= rise_cnt_r + 8'h01;
  end

  ////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  chk_oe_release: assert property (cs_n [*6] |-> !miso_oe)
    else $error("drive output not released");
  chk_oe_hold: assert property ((!cs_n) [*6] |-> miso_oe)
    else $error("selected drive not driving");
  chk_mosi_at_rise: assert property ($rose(sclk) |->
    (mosi == $past(mosi, 8)) ##1 $stable(mosi) [*7])
    else $error("master data moved near rising edge");
  chk_miso_at_rise: assert property ($rose(sclk) |->
    (miso == $past(miso, 8)) ##1 $stable(miso) [*7])
    else $error("drive data moved near rising edge");
  chk_miso_on_fall: assert property (miso_oe && $changed(miso_o) |-> !sclk)
    else $error("drive data changed while clock high");
  chk_duplex_drive: assert property ($rose(sclk) |-> miso_oe)
    else $error("clock edge without drive output");
  chk_half_period: assert property ($fell(sclk) |-> hi_cnt_r == HALF_CYC)
    else $error("link clock high phase wrong length");
  chk_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0)
    else $error("frame ended inside a byte");

  cov_read_frame: cover property ($rose(cs_n) && rise_cnt_r == 8'h80);
  cov_write_frame: cover property ($rose(cs_n) && rise_cnt_r == 8'h78);
  cov_short_frame: cover property ($rose(cs_n) && rise_cnt_r == 8'h30);
endmodule

// ===== tb/tb.sv
// Bench: master end and drive end joined by the link interface.
// Assumes the package defaults, except for a shortened link clock divider.
`timescale 1ns/1ns
module tb;
  import sdspi_pkg::*;
  // A 16-cycle half period keeps the run short and leaves the drive's
  // synchroniser lag well inside each phase of the link clock.
  localparam logic [10:0] TB_HALF_CYC = 11'h010;
  logic       clk;
  logic       d_busy;
  logic       rst;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       hold;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       m_busy;
  logic [7:0] fault;
  logic       enabled;
  logic [7:0] param [NUM_PARAM];
  logic       done;
  logic       err;
  logic       refused;
  int         errors;
  int         samples_checked;
  int         n_done;
  int         n_err;
  int         n_ref;
  logic [7:0] txq [$];
  logic [7:0] rxq [$];

  sdspi_if sdspi_if_i ();
  sdspi_master #(.HALF_CYC(TB_HALF_CYC)) sdspi_master_i (.i_core_clk(clk), .i_rst(rst),
    .bus(sdspi_if_i.master), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .i_hold(hold), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_busy(m_busy));
  sdspi_drive sdspi_drive_i (.i_core_clk(clk), .i_rst(rst), .bus(sdspi_if_i.slave),
    .i_fault(fault), .i_drive_enabled(enabled), .o_param(param), .o_cfg_done(done),
    .o_cfg_err(err), .o_cfg_refused(refused), .o_busy(d_busy));
  sdspi_checker #(.HALF_CYC(TB_HALF_CYC)) sdspi_checker_i (.i_core_clk(clk), .i_rst(rst),
    .sclk(sdspi_if_i.sclk),
    .mosi(sdspi_if_i.mosi), .cs_n(sdspi_if_i.cs_n), .miso_o(sdspi_if_i.miso_o),
    .miso_oe(sdspi_if_i.miso_oe), .miso(sdspi_if_i.miso));

  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    n_done += (done === 1'b1);
    n_err += (err === 1'b1);
    n_ref += (refused === 1'b1);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Sends txq as one frame, holding each byte until the FIFO takes it, and gathers the replies.
  task automatic frame(input int n);
    int a;
    int b;
    rxq = {};
    hold <= 1'b1;
    fork
      begin
        for (a = 0; a < n; a++)
        begin
          tx_valid <= 1'b1;
          tx_data <= txq[a];
          @(negedge clk);
          while (tx_ready !== 1'b1) @(negedge clk);
          @(posedge clk);
        end
        tx_valid <= 1'b0;
      end
      begin
        b = 0;
        while (rxq.size() < n && b < n * 1000)
        begin
          @(negedge clk);
          b++;
          if (rx_valid === 1'b1) rxq.push_back(rx_data);
        end
      end
    join
    @(posedge clk);
    hold <= 1'b0;
    b = 0;
    do
    begin
      @(negedge clk);
      b++;
    end
    while (m_busy !== 1'b0 && b < 3000);
    @(posedge clk);
    chk(8'(rxq.size()), 8'(n));
    chk({7'h00, m_busy}, 8'h00);
    chk({7'h00, d_busy}, 8'h00);
  endtask

  task automatic load_write(input logic [7:0] seed);
    logic [7:0] sum;
    sum = 8'h00;
    txq = {CMD_WRITE_ALL};
    for (int i = 0; i < NUM_PARAM; i++)
    begin
      txq.push_back(seed + 8'(i * 7));
      sum += seed + 8'(i * 7);
    end
    txq.push_back(sum);
  endtask

  task automatic all_fill();
    foreach (rxq[i]) chk(rxq[i], FILL_BYTE);
  endtask

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    hold = 1'b0;
    fault = 8'h3c;
    enabled = 1'b0;
    errors = 0;
    samples_checked = 0;
    n_done = 0;
    n_err = 0;
    n_ref = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < NUM_PARAM; i++) chk(param[i], PARAM_RST[i]);
    $display("reset test done");

    load_write(8'h21);
    frame(15);
    all_fill();
    chk(8'(n_done), 8'h01);
    for (int i = 0; i < NUM_PARAM; i++) chk(param[i], 8'h21 + 8'(i * 7));
    $display("write test done");

    txq = {CMD_READ_ALL};
    repeat (15) txq.push_back(FILL_BYTE);
    frame(16);
    chk(rxq[0], FILL_BYTE);
    chk(rxq[1], READ_HEADER);
    for (int i = 0; i < NUM_PARAM; i++) chk(rxq[2 + i], 8'h21 + 8'(i * 7));
    chk(rxq[15], fault);
    $display("read test done");

    txq = {CMD_WRITE_ALL, 8'h99, 8'h98, 8'h97, 8'h96, 8'h95};
    frame(6);
    chk(8'(n_done + n_err + n_ref), 8'h01);
    for (int i = 0; i < NUM_PARAM; i++) chk(param[i], 8'h21 + 8'(i * 7));
    $display("abort test done");

    enabled <= 1'b1;
    load_write(8'h73);
    frame(15);
    all_fill();
    chk(8'(n_ref), 8'h01);
    chk(8'(n_done), 8'h01);
    for (int i = 0; i < NUM_PARAM; i++) chk(param[i], 8'h21 + 8'(i * 7));
    enabled <= 1'b0;
    $display("refused write test done");

    load_write(8'h55);
    txq[14] = txq[14] ^ 8'h01;
    frame(15);
    all_fill();
    chk(8'(n_err), 8'h01);
    for (int i = 0; i < NUM_PARAM; i++) chk(param[i], 8'h21 + 8'(i * 7));
    $display("bad checksum test done");

    txq = {8'h11, FILL_BYTE, FILL_BYTE};
    frame(3);
    all_fill();
    chk(8'(n_done + n_err + n_ref), 8'h03);
    $display("unknown command test done");
    conclude();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule
